// ==== drbc_top.sv ====
// module: dma channel request recognition and bus request/yield control with axi4-lite registers
// Notes on behaviour
// - request source bit 14 at 1 takes requests from the interrupt or pin input, at 0 from software.
// - polarity bit 13 only matters for external requests and is ignored for software requests.
// - polarity 0 means falling edge or low level is active, and software must never write 1.
// - the transfer acknowledge toward the external requester is driven active low.
// - sensing bit 12 at 1 takes a held low pin as a request, at 0 a falling edge of the pin.
// - the sensing bit only acts under external requests and is ignored under software requests.
// - snoop bit 11 at 1 uses the snoop bus request, at 0 the plain bus request.
// - the yield enable at bit 10 only applies to a bus taken by plain request.
// - with yield enabled and the bus owned, a core release request returns the bus at a pause.
// - after reset all five control fields read 0.
`timescale 1ns/10ps
`default_nettype none
module drbc_top (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic [31:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [31:0] I_ARADDR,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic I_INTERRUPT_TRANSFER_REQUEST_N,
  input wire logic I_PIN_TRANSFER_REQUEST_N,
  output logic O_TRANSFER_ACKNOWLEDGE_N,
  output logic O_SNOOP_BUS_REQUEST,
  output logic O_PLAIN_BUS_REQUEST,
  input wire logic I_BUS_GRANT,
  input wire logic I_BUS_RELEASE_REQUEST,
  input wire logic I_BUS_OP_PAUSE,
  input wire logic I_XFER_VALID,
  output logic O_XFER_READY,
  input wire logic [31:0] I_XFER_DATA
);
  logic [31:0] ctrl_q;
  logic soft_req_q;
  logic [1:0] pin_sync_q;
  logic [1:0] int_sync_q;
  logic pin_prev_q;
  logic ext_pending_q;
  logic ext_req;
  logic req_pending;
  logic ext_select;
  logic level_mode;
  logic snoop_sel;
  logic yield_en;
  drbc_pkg::drbc_bus_state_t bus_state_q;
  logic snoop_req_q;
  logic plain_req_q;
  logic ack_n_q;
  logic xfer_ready_q;
  logic owned_by_snoop_q;
  logic aw_held_q;
  logic w_held_q;
  logic [31:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_go;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic fifo_push;
  logic [31:0] fifo_out_data;
  logic [3:0] fifo_count;

  function automatic logic [31:0] apply_strobe(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  function automatic logic addr_known(input logic [31:0] a);
    return (a == drbc_pkg::CHANNEL_CONTROL_ADDR) || (a == drbc_pkg::STATUS_ADDR) ||
           (a == drbc_pkg::SOFT_REQUEST_ADDR) || (a == drbc_pkg::FIFO_DATA_ADDR);
  endfunction

  assign ext_select = ctrl_q[drbc_pkg::REQ_SRC_BIT];
  assign level_mode = ctrl_q[drbc_pkg::LEVEL_MODE_BIT];
  assign snoop_sel = ctrl_q[drbc_pkg::SNOOP_SEL_BIT];
  assign yield_en = ctrl_q[drbc_pkg::YIELD_EN_BIT];

  // write path: address and data are taken independently, response after both
  assign wr_go = aw_held_q && w_held_q && !bvalid_q;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      aw_addr_q <= 32'h0000_0000;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= drbc_pkg::RESP_OKAY;
    end else begin
      awready_q <= !aw_held_q && !awready_q;
      wready_q <= !w_held_q && !wready_q;
      if (I_AWVALID && awready_q) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= I_AWADDR;
        awready_q <= 1'b0;
      end
      if (I_WVALID && wready_q) begin
        w_held_q <= 1'b1;
        w_data_q <= I_WDATA;
        w_strb_q <= I_WSTRB;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= addr_known(aw_addr_q) ? drbc_pkg::RESP_OKAY : drbc_pkg::RESP_SLVERR;
      end
      if (bvalid_q && I_BREADY) begin
        bvalid_q <= 1'b0;
        aw_held_q <= 1'b0;
        w_held_q <= 1'b0;
      end
    end
  end

  // control register: only the five request/bus fields are implemented
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ctrl_q <= drbc_pkg::CTRL_RESET;
    end else if (wr_go && aw_addr_q == drbc_pkg::CHANNEL_CONTROL_ADDR) begin
      // polarity 1 is prohibited; the bit is stored but recognition stays active low
      ctrl_q <= apply_strobe(ctrl_q, w_data_q, w_strb_q) & drbc_pkg::CTRL_WRITE_MASK;
    end
  end

  // software request: set by write, cleared when the bus is taken; set wins
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      soft_req_q <= 1'b0;
    end else if (wr_go && aw_addr_q == drbc_pkg::SOFT_REQUEST_ADDR &&
                 w_strb_q[0] && w_data_q[0]) begin
      soft_req_q <= 1'b1;
    end else if (bus_state_q == drbc_pkg::BUS_WAIT && I_BUS_GRANT && !ext_select) begin
      soft_req_q <= 1'b0;
    end
  end

  // read path
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= drbc_pkg::RESP_OKAY;
    end else begin
      arready_q <= !rvalid_q && !arready_q;
      if (I_ARVALID && arready_q) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rresp_q <= addr_known(I_ARADDR) ? drbc_pkg::RESP_OKAY : drbc_pkg::RESP_SLVERR;
        case (I_ARADDR)
          drbc_pkg::CHANNEL_CONTROL_ADDR: begin
            rdata_q <= ctrl_q;
          end
          drbc_pkg::STATUS_ADDR: begin
            rdata_q <= {20'h00000, fifo_count, bus_state_q, ext_pending_q, soft_req_q,
                        snoop_req_q, plain_req_q};
          end
          drbc_pkg::SOFT_REQUEST_ADDR: begin
            rdata_q <= {31'h0, soft_req_q};
          end
          drbc_pkg::FIFO_DATA_ADDR: begin
            rdata_q <= fifo_out_data;
          end
          default: begin
            rdata_q <= 32'h0000_0000;
          end
        endcase
      end else if (rvalid_q && I_RREADY) begin
        rvalid_q <= 1'b0;
      end
    end
  end

  // two-stage synchronisers on both request inputs
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      pin_sync_q <= 2'h3;
      int_sync_q <= 2'h3;
      pin_prev_q <= 1'b1;
    end else begin
      pin_sync_q <= {pin_sync_q[0], I_PIN_TRANSFER_REQUEST_N};
      int_sync_q <= {int_sync_q[0], I_INTERRUPT_TRANSFER_REQUEST_N};
      pin_prev_q <= pin_sync_q[1];
    end
  end

  // edge mode latches a falling edge until served; level mode follows the low level
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ext_pending_q <= 1'b0;
    end else if (ext_select && !level_mode && pin_prev_q && !pin_sync_q[1]) begin
      ext_pending_q <= 1'b1;
    end else if (!ext_select || level_mode ||
                 (bus_state_q == drbc_pkg::BUS_WAIT && I_BUS_GRANT)) begin
      ext_pending_q <= 1'b0;
    end
  end

  // polarity is fixed active low; the prohibited setting is not honoured
  // interrupt source is level only, so software must pick level mode for it
  assign ext_req = level_mode ? (!pin_sync_q[1] || !int_sync_q[1]) : ext_pending_q;
  assign req_pending = ext_select ? ext_req : soft_req_q;

  // bus request / ownership / yield
  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      bus_state_q <= drbc_pkg::BUS_IDLE;
      snoop_req_q <= 1'b0;
      plain_req_q <= 1'b0;
      owned_by_snoop_q <= 1'b0;
    end else begin
      case (bus_state_q)
        drbc_pkg::BUS_IDLE: begin
          if (req_pending && fifo_out_valid) begin
            bus_state_q <= drbc_pkg::BUS_WAIT;
            snoop_req_q <= snoop_sel;
            plain_req_q <= !snoop_sel;
            owned_by_snoop_q <= snoop_sel;
          end
        end
        drbc_pkg::BUS_WAIT: begin
          if (I_BUS_GRANT) begin
            bus_state_q <= drbc_pkg::BUS_OWN;
          end
        end
        drbc_pkg::BUS_OWN: begin
          if (!owned_by_snoop_q && yield_en && I_BUS_RELEASE_REQUEST) begin
            bus_state_q <= drbc_pkg::BUS_YIELD;
          end else if (fifo_pop) begin
            bus_state_q <= drbc_pkg::BUS_IDLE;
            snoop_req_q <= 1'b0;
            plain_req_q <= 1'b0;
          end
        end
        drbc_pkg::BUS_YIELD: begin
          if (I_BUS_OP_PAUSE) begin
            bus_state_q <= drbc_pkg::BUS_IDLE;
            snoop_req_q <= 1'b0;
            plain_req_q <= 1'b0;
          end
        end
        default: begin
          bus_state_q <= drbc_pkg::BUS_IDLE;
          snoop_req_q <= 1'b0;
          plain_req_q <= 1'b0;
        end
      endcase
    end
  end

  // one word leaves the fifo per bus tenure unless it is yielded; acknowledge pulses low the cycle after, for external requests only
  assign fifo_pop = bus_state_q == drbc_pkg::BUS_OWN && fifo_out_valid &&
                    !(!owned_by_snoop_q && yield_en && I_BUS_RELEASE_REQUEST);
  assign fifo_push = I_XFER_VALID && xfer_ready_q && fifo_in_ready;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_SYS_RST) begin
      ack_n_q <= 1'b1;
      xfer_ready_q <= 1'b0;
    end else begin
      ack_n_q <= !(fifo_pop && ext_select);
      // ready follows the count after this edge, so a word offered while ready is high is kept
      xfer_ready_q <= (fifo_count + 4'(fifo_push) - 4'(fifo_pop)) != 4'(drbc_pkg::FIFO_DEPTH);
    end
  end

  drbc_fifo #(
    .WIDTH(drbc_pkg::FIFO_WIDTH),
    .DEPTH(drbc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk(I_CLK_SYS),
    .i_rst(I_SYS_RST),
    .i_in_valid(fifo_push),
    .o_in_ready(fifo_in_ready),
    .i_in_data(I_XFER_DATA),
    .o_out_valid(fifo_out_valid),
    .i_out_ready(fifo_pop),
    .o_out_data(fifo_out_data),
    .o_count(fifo_count)
  );

  assign O_AWREADY = awready_q;
  assign O_WREADY = wready_q;
  assign O_BVALID = bvalid_q;
  assign O_BRESP = bresp_q;
  assign O_ARREADY = arready_q;
  assign O_RVALID = rvalid_q;
  assign O_RDATA = rdata_q;
  assign O_RRESP = rresp_q;
  assign O_TRANSFER_ACKNOWLEDGE_N = ack_n_q;
  assign O_SNOOP_BUS_REQUEST = snoop_req_q;
  assign O_PLAIN_BUS_REQUEST = plain_req_q;
  assign O_XFER_READY = xfer_ready_q;
endmodule
`default_nettype wire

// ==== drbc_pkg.sv ====
// package: register map, field positions, reset values and states for the request/bus control block
package drbc_pkg;
  localparam logic [31:0] CHANNEL_CONTROL_ADDR = 32'h0000_0000;
  localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
  localparam logic [31:0] SOFT_REQUEST_ADDR = 32'h0000_0008;
  localparam logic [31:0] FIFO_DATA_ADDR = 32'h0000_000C;
  localparam int REQ_SRC_BIT = 14;
  localparam int REQ_POL_BIT = 13;
  localparam int LEVEL_MODE_BIT = 12;
  localparam int SNOOP_SEL_BIT = 11;
  localparam int YIELD_EN_BIT = 10;
  localparam logic [31:0] CTRL_WRITE_MASK = 32'h0000_7C00;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_WIDTH = 32;
  localparam int FIFO_DEPTH = 8;
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WAIT = 4'h2,
    BUS_OWN = 4'h4,
    BUS_YIELD = 4'h8
  } drbc_bus_state_t;
endpackage

// ==== drbc_fifo.sv ====
// module: small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
`default_nettype none
module drbc_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [$clog2(DEPTH):0] o_count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic push;
  logic pop;

  assign o_in_ready = (count_q != DEPTH[AW:0]);
  assign o_out_valid = (count_q != '0);
  assign o_out_data = mem_q[rd_ptr_q];
  assign o_count = count_q;
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= i_in_data;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
      end
      if (pop) begin
        rd_ptr_q <= (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== drbc_arbiter_model.sv ====
// partner: bus arbiter and core model facing the request/bus control block
`timescale 1ns/10ps
`default_nettype none
module drbc_arbiter_model (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_snoop_req,
  input wire logic i_plain_req,
  input wire logic i_slow,
  input wire logic i_release_ask,
  output logic o_grant,
  output logic o_release_req,
  output logic o_pause
);
  logic [3:0] wait_q;
  always_ff @(posedge i_clk) begin
    if (i_rst || !(i_snoop_req || i_plain_req)) begin
      wait_q <= 4'h0;
    end else if (wait_q != 4'hF) begin
      wait_q <= wait_q + 4'h1;
    end
  end
  // either request kind is served; slow mode stalls the grant to fill the fifo
  always_ff @(posedge i_clk) begin
    o_grant <= !i_rst && (i_snoop_req || i_plain_req) && (wait_q >= (i_slow ? 4'h6 : 4'h1));
  end
  // the core can only ask back a bus taken by plain request
  always_ff @(posedge i_clk) begin
    o_release_req <= !i_rst && i_release_ask && o_grant && i_plain_req;
  end
  // pauses between bus operations come every other cycle
  always_ff @(posedge i_clk) begin
    o_pause <= !i_rst && !o_pause;
  end
endmodule
`default_nettype wire

// ==== drbc_bus_monitor.sv ====
// checker: port-level assertions for the request/bus control block
`timescale 1ns/10ps
`default_nettype none
module drbc_bus_monitor (
  input wire logic I_CLK_SYS,
  input wire logic I_SYS_RST,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic O_TRANSFER_ACKNOWLEDGE_N,
  input wire logic O_SNOOP_BUS_REQUEST,
  input wire logic O_PLAIN_BUS_REQUEST,
  input wire logic I_BUS_GRANT
);
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (I_SYS_RST);
  reset_idle_a: assert property ($past(I_SYS_RST) |->
    !O_SNOOP_BUS_REQUEST && !O_PLAIN_BUS_REQUEST && O_TRANSFER_ACKNOWLEDGE_N && !O_BVALID)
    else $error("outputs not idle after reset");
  ack_pulse_a: assert property (!O_TRANSFER_ACKNOWLEDGE_N |=> O_TRANSFER_ACKNOWLEDGE_N)
    else $error("acknowledge low longer than one cycle");
  ack_granted_a: assert property ($fell(O_TRANSFER_ACKNOWLEDGE_N) |-> $past(I_BUS_GRANT))
    else $error("acknowledge without bus ownership");
  req_excl_a: assert property (!(O_SNOOP_BUS_REQUEST && O_PLAIN_BUS_REQUEST))
    else $error("snoop and plain request together");
  req_hold_a: assert property ((O_SNOOP_BUS_REQUEST || O_PLAIN_BUS_REQUEST) && !I_BUS_GRANT
    |=> O_SNOOP_BUS_REQUEST || O_PLAIN_BUS_REQUEST)
    else $error("bus request dropped before grant");
  read_answer_a: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
    else $error("read answer late");
  write_end_a: assert property (O_BVALID && I_BREADY |=> !O_BVALID)
    else $error("write response repeated");
  read_end_a: assert property (O_RVALID && I_RREADY |=> !O_RVALID)
    else $error("read response repeated");
endmodule
bind drbc_top drbc_bus_monitor u_monitor (
  .I_CLK_SYS(I_CLK_SYS),
  .I_SYS_RST(I_SYS_RST),
  .I_ARVALID(I_ARVALID),
  .O_ARREADY(O_ARREADY),
  .O_RVALID(O_RVALID),
  .I_RREADY(I_RREADY),
  .O_BVALID(O_BVALID),
  .I_BREADY(I_BREADY),
  .O_TRANSFER_ACKNOWLEDGE_N(O_TRANSFER_ACKNOWLEDGE_N),
  .O_SNOOP_BUS_REQUEST(O_SNOOP_BUS_REQUEST),
  .O_PLAIN_BUS_REQUEST(O_PLAIN_BUS_REQUEST),
  .I_BUS_GRANT(I_BUS_GRANT)
);
`default_nettype wire

// ==== drbc_top_tb_top.sv ====
// testbench: register, request mode and bus ownership scenarios
`timescale 1ns/10ps
`default_nettype none
module drbc_top_tb_top;
  logic clk, rst, awv, wv, bready, arv, rready, pin_n, int_n, xv, slow, ask;
  logic awr, wr, bv, arr, rv, ack_n, snoop_bus_request, preq, grant, rel, pause, xr;
  logic [31:0] awa, wd, ara, rd, xd, v;
  logic [1:0] br, rr, resp;
  int err_total, samples_checked, acks, sns, pls, a0, s0, p0;
  localparam logic [31:0] ctl = drbc_pkg::CHANNEL_CONTROL_ADDR;
  localparam logic [31:0] swr = drbc_pkg::SOFT_REQUEST_ADDR;
  drbc_top dut (.I_CLK_SYS(clk), .I_SYS_RST(rst), .I_AWADDR(awa), .I_AWVALID(awv),
    .O_AWREADY(awr), .I_WDATA(wd), .I_WSTRB(4'hF), .I_WVALID(wv), .O_WREADY(wr),
    .O_BRESP(br), .O_BVALID(bv), .I_BREADY(bready), .I_ARADDR(ara), .I_ARVALID(arv),
    .O_ARREADY(arr), .O_RDATA(rd), .O_RRESP(rr), .O_RVALID(rv), .I_RREADY(rready),
    .I_INTERRUPT_TRANSFER_REQUEST_N(int_n), .I_PIN_TRANSFER_REQUEST_N(pin_n),
    .O_TRANSFER_ACKNOWLEDGE_N(ack_n), .O_SNOOP_BUS_REQUEST(snoop_bus_request), .O_PLAIN_BUS_REQUEST(preq),
    .I_BUS_GRANT(grant), .I_BUS_RELEASE_REQUEST(rel), .I_BUS_OP_PAUSE(pause),
    .I_XFER_VALID(xv), .O_XFER_READY(xr), .I_XFER_DATA(xd));
  drbc_arbiter_model u_arb (.i_clk(clk), .i_rst(rst), .i_snoop_req(snoop_bus_request), .i_plain_req(preq),
    .i_slow(slow), .i_release_ask(ask), .o_grant(grant), .o_release_req(rel), .o_pause(pause));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // cycle counts of acknowledge and each request kind, compared before and after
  always @(posedge clk) begin
    if (ack_n === 1'b0) acks++;
    if (snoop_bus_request === 1'b1) sns++;
    if (preq === 1'b1) pls++;
  end
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("unexpected %s expected %h seen %h", s, e, g);
      err_total++;
    end
  endtask
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // starts one edge after the last task so no signal is assigned twice in a step
  task wrr(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awr === 1'b1) awv <= 1'b0;
      if (wr === 1'b1) wv <= 1'b0;
    end while (bv !== 1'b1);
    bready <= 1'b0;
    chk("write response", {30'h0, drbc_pkg::RESP_OKAY}, {30'h0, br});
  endtask
  task rdr(input logic [31:0] a);
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arr === 1'b1) arv <= 1'b0;
    end while (rv !== 1'b1);
    v = rd;
    resp = rr;
    rready <= 1'b0;
  endtask
  task push(input logic [31:0] d);
    @(posedge clk);
    xd <= d;
    xv <= 1'b1;
    do begin
      @(posedge clk);
    end while (xr !== 1'b1);
    xv <= 1'b0;
  endtask
  // polls status until the masked field reaches the value, bounded
  task wait_st(input string s, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    do begin
      rdr(drbc_pkg::STATUS_ADDR);
      n++;
    end while ((v & m) !== e && n < 80);
    chk(s, e, v & m);
  endtask
  initial begin
    {rst, pin_n, int_n} = 3'h7;
    {awv, wv, bready, arv, rready, xv, slow, ask} = 8'h00;
    {awa, wd, ara, xd} = 128'h0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rdr(ctl);
    chk("control after reset", 32'h0, v);
    rdr(32'h0000_0010);
    chk("unmapped response", {30'h0, drbc_pkg::RESP_SLVERR}, {30'h0, resp});
    wrr(ctl, 32'hFFFF_DFFF);
    rdr(ctl);
    chk("control fields", 32'h0000_5C00, v);
    $display("test registers done");
    wrr(ctl, 32'h0);
    push(32'hA5A5_0001);
    rdr(drbc_pkg::FIFO_DATA_ADDR);
    chk("fifo head", 32'hA5A5_0001, v);
    {a0, s0, p0} = {acks, sns, pls};
    wrr(swr, 32'h1);
    wait_st("soft drain", 32'h0F00, 32'h0);
    chk("soft acknowledge", a0, acks);
    chk("soft snoop", s0, sns);
    chk("soft plain", 32'h1, {31'h0, pls > p0});
    $display("test soft request done");
    wrr(ctl, 32'h0000_4800);
    push(32'hA5A5_0002);
    push(32'hA5A5_0003);
    {a0, s0, p0} = {acks, sns, pls};
    pin_n <= 1'b0;
    wait_st("edge one word", 32'h0F00, 32'h0100);
    repeat (20) @(posedge clk);
    wait_st("edge held low", 32'h0F00, 32'h0100);
    chk("edge acknowledge", a0 + 1, acks);
    chk("edge snoop", 32'h1, {31'h0, sns > s0});
    chk("edge plain", p0, pls);
    $display("test edge mode done");
    wrr(ctl, 32'h0000_1000);
    int_n <= 1'b0;
    repeat (30) @(posedge clk);
    wait_st("soft ignores pins", 32'h0F00, 32'h0100);
    a0 = acks;
    wrr(swr, 32'h1);
    wait_st("soft with pins low", 32'h0F00, 32'h0);
    chk("soft no acknowledge", a0, acks);
    int_n <= 1'b1;
    pin_n <= 1'b1;
    $display("test mode ignore done");
    for (int i = 0; i < 8; i++) push(32'hC0DE_0000 + i);
    repeat (2) @(posedge clk);
    chk("full ready", 32'h0, {31'h0, xr});
    wait_st("fifo full", 32'h0F00, 32'h0800);
    slow <= 1'b1;
    ask <= 1'b1;
    a0 = acks;
    wrr(ctl, 32'h0000_5000);
    int_n <= 1'b0;
    wait_st("level drain", 32'h0F00, 32'h0);
    chk("level acknowledges", a0 + 8, acks);
    int_n <= 1'b1;
    slow <= 1'b0;
    $display("test level fill done");
    wrr(ctl, 32'h0000_0400);
    ask <= 1'b1;
    p0 = pls;
    push(32'hA5A5_0004);
    wrr(swr, 32'h1);
    wait_st("yield idle", 32'h00F0, {24'h0, drbc_pkg::BUS_IDLE, 4'h0});
    chk("yield plain", 32'h1, {31'h0, pls > p0});
    wait_st("yield kept word", 32'h0F00, 32'h0100);
    ask <= 1'b0;
    $display("test yield done");
    report_and_stop();
  end
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
endmodule
`default_nettype wire
